// ### src/flash_cmd_decoder.sv
// Device end: deserialises frames and decodes program and erase commands.
`timescale 1ns/1ps
module flash_cmd_decoder (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Serial link
   flash_link_if.dev link,
   // Configuration
   input wire logic pageMode528,
   // Decoded command
   output logic cmdValid,
   output flash_cmd_pkg::cmd_t cmdKind,
   output logic [7:0] cmdOpcode,
   output logic bufferTwo,
   output logic withErase,
   output logic offsetValid,
   output logic [flash_cmd_pkg::PAGE_W-1:0] pageNum,
   output logic [9:0] byteOffset,
   output logic [flash_cmd_pkg::BLOCK_W-1:0] blockNum,
   // Frame ended after its opcode byte without a complete command
   output logic cmdReject
);
   import flash_cmd_pkg::*;

   // -------------------------------------------------------------
   // Frame state
   // -------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OPC = 3'b000,
      ST_ADDR = 3'b001,
      ST_CHIP = 3'b010,
      ST_HELD = 3'b011,
      ST_DROP = 3'b100
   } dstate_t;

   dstate_t state_r, state_nxt;
   logic sclkPrev_r;
   logic csPrev_r;
   logic [2:0] bitCnt_r, bitCnt_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [1:0] byteCnt_r, byteCnt_nxt;
   logic [7:0] opcode_r, opcode_nxt;
   logic [23:0] addr_r, addr_nxt;
   logic sclkRise;
   logic frameEnd;
   logic [7:0] byteIn;
   logic [7:0] chipExpect;
   logic [FIELD_W-1:0] field;
   cmd_t opKind;

   // -------------------------------------------------------------
   // Output state
   // -------------------------------------------------------------
   logic cmdValid_nxt, cmdReject_nxt;
   cmd_t cmdKind_nxt;
   logic [7:0] cmdOpcode_nxt;
   logic bufferTwo_nxt, withErase_nxt, offsetValid_nxt;
   logic [PAGE_W-1:0] pageNum_nxt;
   logic [9:0] byteOffset_nxt;
   logic [BLOCK_W-1:0] blockNum_nxt;

   assign sclkRise = link.sclk & ~sclkPrev_r;
   assign frameEnd = link.csN & ~csPrev_r;
   assign byteIn = {shift_r[6:0], link.mosi};
   assign opKind = decodeOp(opcode_r);
   assign field = pageField(addr_r, pageMode528);

   always_comb begin
      unique case (byteCnt_r)
         2'd1: chipExpect = CHIP_SEQ1;
         2'd2: chipExpect = CHIP_SEQ2;
         2'd3: chipExpect = CHIP_SEQ3;
         default: chipExpect = CHIP_SEQ0;
      endcase
   end

   // -------------------------------------------------------------
   // Byte collection
   // -------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      bitCnt_nxt = bitCnt_r;
      shift_nxt = shift_r;
      byteCnt_nxt = byteCnt_r;
      opcode_nxt = opcode_r;
      addr_nxt = addr_r;
      if (link.csN) begin
         // A raised select always rearms opcode capture.
         state_nxt = ST_OPC;
         bitCnt_nxt = 3'd0;
         byteCnt_nxt = 2'd0;
      end else if (sclkRise) begin
         shift_nxt = byteIn;
         bitCnt_nxt = bitCnt_r + 3'd1;
         if (bitCnt_r == 3'd7) begin
            unique case (state_r)
               ST_OPC: begin
                  opcode_nxt = byteIn;
                  addr_nxt = 24'h00_0000;
                  byteCnt_nxt = 2'd0;
                  unique case (decodeOp(byteIn))
                     CMD_NONE: state_nxt = ST_DROP;
                     CMD_SUSPEND, CMD_RESUME: state_nxt = ST_HELD;
                     CMD_CHIP_ERASE: begin
                        state_nxt = ST_CHIP;
                        byteCnt_nxt = 2'd1;
                     end
                     default: state_nxt = ST_ADDR;
                  endcase
               end
               ST_ADDR: begin
                  addr_nxt = {addr_r[15:0], byteIn};
                  byteCnt_nxt = byteCnt_r + 2'd1;
                  if (byteCnt_r == 2'(ADDR_BYTES - 1)) begin
                     state_nxt = ST_HELD;
                  end
               end
               ST_CHIP: begin
                  if (byteIn != chipExpect) begin
                     state_nxt = ST_DROP;
                  end else if (byteCnt_r == 2'(CHIP_BYTES - 1)) begin
                     state_nxt = ST_HELD;
                  end else begin
                     byteCnt_nxt = byteCnt_r + 2'd1;
                  end
               end
               ST_HELD: state_nxt = ST_HELD;
               ST_DROP: state_nxt = ST_DROP;
               default: state_nxt = ST_DROP;
            endcase
         end
      end
   end

   // -------------------------------------------------------------
   // Command issue at the end of the frame
   // -------------------------------------------------------------
   // The operation starts only when select rises, so a frame cut short
   // never launches anything; it is reported once its opcode byte is in.
   always_comb begin
      cmdValid_nxt = 1'b0;
      cmdReject_nxt = 1'b0;
      cmdKind_nxt = cmdKind;
      cmdOpcode_nxt = cmdOpcode;
      bufferTwo_nxt = bufferTwo;
      withErase_nxt = withErase;
      offsetValid_nxt = offsetValid;
      pageNum_nxt = pageNum;
      byteOffset_nxt = byteOffset;
      blockNum_nxt = blockNum;
      if (frameEnd && state_r == ST_HELD) begin
         cmdValid_nxt = 1'b1;
         cmdKind_nxt = opKind;
         cmdOpcode_nxt = opcode_r;
         bufferTwo_nxt = (opcode_r == OP_B2_PAGE_ERASE) ||
            (opcode_r == OP_B2_PAGE_NOERASE) ||
            (opcode_r == OP_B2_BYTE_ERASE);
         withErase_nxt = (opcode_r == OP_B1_PAGE_ERASE) ||
            (opcode_r == OP_B2_PAGE_ERASE) ||
            (opcode_r == OP_B1_BYTE_ERASE) ||
            (opcode_r == OP_B2_BYTE_ERASE);
         offsetValid_nxt = 1'b0;
         pageNum_nxt = '0;
         byteOffset_nxt = '0;
         blockNum_nxt = '0;
         unique case (opKind)
            CMD_BUF_PROG: begin
               pageNum_nxt = field[PAGE_W-1:0];
            end
            CMD_BYTE_PROG: begin
               pageNum_nxt = field[PAGE_W-1:0];
               offsetValid_nxt = 1'b1;
               byteOffset_nxt = pageMode528 ? addr_r[9:0] :
                  {1'b0, addr_r[8:0]};
            end
            CMD_BLOCK_ERASE: begin
               blockNum_nxt = field[BLOCK_LSB +: BLOCK_W];
            end
            default: begin
               pageNum_nxt = '0;
            end
         endcase
      end else if (frameEnd && state_r != ST_OPC) begin
         cmdReject_nxt = 1'b1;
      end
   end

   // -------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ST_OPC;
         sclkPrev_r <= 1'b0;
         csPrev_r <= 1'b1;
         bitCnt_r <= 3'd0;
         shift_r <= 8'h00;
         byteCnt_r <= 2'd0;
         opcode_r <= 8'h00;
         addr_r <= 24'h00_0000;
         cmdValid <= 1'b0;
         cmdReject <= 1'b0;
         cmdKind <= CMD_NONE;
         cmdOpcode <= 8'h00;
         bufferTwo <= 1'b0;
         withErase <= 1'b0;
         offsetValid <= 1'b0;
         pageNum <= '0;
         byteOffset <= 10'h000;
         blockNum <= '0;
      end else begin
         state_r <= state_nxt;
         sclkPrev_r <= link.sclk;
         csPrev_r <= link.csN;
         bitCnt_r <= bitCnt_nxt;
         shift_r <= shift_nxt;
         byteCnt_r <= byteCnt_nxt;
         opcode_r <= opcode_nxt;
         addr_r <= addr_nxt;
         cmdValid <= cmdValid_nxt;
         cmdReject <= cmdReject_nxt;
         cmdKind <= cmdKind_nxt;
         cmdOpcode <= cmdOpcode_nxt;
         bufferTwo <= bufferTwo_nxt;
         withErase <= withErase_nxt;
         offsetValid <= offsetValid_nxt;
         pageNum <= pageNum_nxt;
         byteOffset <= byteOffset_nxt;
         blockNum <= blockNum_nxt;
      end
   end

endmodule

// ### src/flash_cmd_pkg.sv
// Shared constants, types and helpers for the flash command link.
// Function
// - 83h/88h buffer one page program, offset dummy
// - 86h/89h buffer two, 512 page A[21:9]
// - 82h/85h/02h program with real byte offset
// - Address 23 or 22 bits, no dummies
// - 50h block erase from page bits 14:3
// - Chip erase needs C7h 94h 80h 9Ah
// - B0h suspend, D0h resume, extra ignored
package flash_cmd_pkg;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int SCLK_HALF_NS = 50;
   localparam int SCLK_HALF_CYC =
      (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CS_IDLE_NS = 50;
   localparam int CS_IDLE_CYC =
      (CS_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // -------------------------------------------------------------
   // Opcodes
   // -------------------------------------------------------------
   localparam logic [7:0] OP_B1_PAGE_ERASE = 8'h83;
   localparam logic [7:0] OP_B2_PAGE_ERASE = 8'h86;
   localparam logic [7:0] OP_B1_PAGE_NOERASE = 8'h88;
   localparam logic [7:0] OP_B2_PAGE_NOERASE = 8'h89;
   localparam logic [7:0] OP_B1_BYTE_ERASE = 8'h82;
   localparam logic [7:0] OP_B2_BYTE_ERASE = 8'h85;
   localparam logic [7:0] OP_B1_BYTE_NOERASE = 8'h02;
   localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
   localparam logic [7:0] OP_SUSPEND = 8'hB0;
   localparam logic [7:0] OP_RESUME = 8'hD0;
   localparam logic [7:0] CHIP_SEQ0 = 8'hC7;
   localparam logic [7:0] CHIP_SEQ1 = 8'h94;
   localparam logic [7:0] CHIP_SEQ2 = 8'h80;
   localparam logic [7:0] CHIP_SEQ3 = 8'h9A;

   // -------------------------------------------------------------
   // Address layout
   // -------------------------------------------------------------
   localparam int ADDR_BYTES = 3;
   localparam int CHIP_BYTES = 4;
   localparam int OFS_W_528 = 10;
   localparam int OFS_W_512 = 9;
   localparam int PAGE_W = 13;
   localparam int FIELD_W = 15;
   localparam int BLOCK_LSB = 3;
   localparam int BLOCK_W = 12;

   typedef enum logic [2:0] {
      CMD_NONE = 3'b000,
      CMD_BUF_PROG = 3'b001,
      CMD_BYTE_PROG = 3'b010,
      CMD_BLOCK_ERASE = 3'b011,
      CMD_CHIP_ERASE = 3'b100,
      CMD_SUSPEND = 3'b101,
      CMD_RESUME = 3'b110
   } cmd_t;

   // Classifies the first byte of a frame.
   function automatic cmd_t decodeOp(input logic [7:0] op);
      unique case (op)
         OP_B1_PAGE_ERASE, OP_B2_PAGE_ERASE,
         OP_B1_PAGE_NOERASE, OP_B2_PAGE_NOERASE: decodeOp = CMD_BUF_PROG;
         OP_B1_BYTE_ERASE, OP_B2_BYTE_ERASE,
         OP_B1_BYTE_NOERASE: decodeOp = CMD_BYTE_PROG;
         OP_BLOCK_ERASE: decodeOp = CMD_BLOCK_ERASE;
         CHIP_SEQ0: decodeOp = CMD_CHIP_ERASE;
         OP_SUSPEND: decodeOp = CMD_SUSPEND;
         OP_RESUME: decodeOp = CMD_RESUME;
         default: decodeOp = CMD_NONE;
      endcase
   endfunction

   // Page field, 15 bits, from a 24-bit address for either page size.
   function automatic logic [FIELD_W-1:0] pageField(
      input logic [23:0] addr, input logic mode528);
      if (mode528) begin
         pageField = {1'b0, addr[23:OFS_W_528]};
      end else begin
         pageField = addr[23:OFS_W_512];
      end
   endfunction

   // Builds the 24-bit address from page field and byte offset.
   function automatic logic [23:0] packAddr(
      input logic [FIELD_W-1:0] page, input logic [9:0] ofs,
      input logic mode528);
      if (mode528) begin
         packAddr = {page[13:0], ofs};
      end else begin
         packAddr = {page, ofs[8:0]};
      end
   endfunction

endpackage

// ### src/flash_link_if.sv
// Serial link between the command issuer and the command decoder.
`timescale 1ns/1ps
interface flash_link_if;
   logic sclk;
   logic csN;
   logic mosi;
   modport dev (input sclk, input csN, input mosi);
   modport ctl (output sclk, output csN, output mosi);
endinterface

// ### src/flash_cmd_issuer.sv
// Host end: serialises one command frame per request onto the link.
`timescale 1ns/1ps
module flash_cmd_issuer (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Serial link
   flash_link_if.ctl link,
   // Configuration
   input wire logic pageMode528,
   // Request
   input wire logic reqValid,
   input wire logic [7:0] reqOpcode,
   input wire logic [flash_cmd_pkg::FIELD_W-1:0] reqPage,
   input wire logic [9:0] reqOffset,
   output logic reqReady
);
   import flash_cmd_pkg::*;

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_LOW = 2'b01,
      H_HIGH = 2'b10,
      H_GAP = 2'b11
   } hstate_t;

   hstate_t state_r, state_nxt;
   logic [31:0] frame_r, frame_nxt;
   logic [5:0] bitsLeft_r, bitsLeft_nxt;
   logic [3:0] tick_r, tick_nxt;
   logic sclk_r, sclk_nxt;
   logic csN_r, csN_nxt;
   logic [FIELD_W-1:0] sendPage;
   cmd_t reqKind;

   assign reqKind = decodeOp(reqOpcode);
   assign reqReady = (state_r == H_IDLE);
   assign link.sclk = sclk_r;
   assign link.csN = csN_r;
   assign link.mosi = frame_r[31];

   // low page bits sent as zero
   assign sendPage = (reqKind == CMD_BLOCK_ERASE) ?
      {reqPage[FIELD_W-1:BLOCK_LSB], 3'b000} : reqPage;

   always_comb begin
      state_nxt = state_r;
      frame_nxt = frame_r;
      bitsLeft_nxt = bitsLeft_r;
      tick_nxt = tick_r;
      sclk_nxt = sclk_r;
      csN_nxt = csN_r;
      unique case (state_r)
         H_IDLE: begin
            if (reqValid) begin
               state_nxt = H_LOW;
               csN_nxt = 1'b0;
               tick_nxt = 4'd0;
               unique case (reqKind)
                  CMD_CHIP_ERASE: begin
                     frame_nxt = {CHIP_SEQ0, CHIP_SEQ1, CHIP_SEQ2, CHIP_SEQ3};
                     bitsLeft_nxt = 6'(8 * CHIP_BYTES);
                  end
                  CMD_SUSPEND, CMD_RESUME, CMD_NONE: begin
                     frame_nxt = {reqOpcode, 24'h00_0000};
                     bitsLeft_nxt = 6'd8;
                  end
                  default: begin
                     frame_nxt = {reqOpcode,
                        packAddr(sendPage, reqOffset, pageMode528)};
                     bitsLeft_nxt = 6'(8 * (ADDR_BYTES + 1));
                  end
               endcase
            end
         end
         H_LOW: begin
            tick_nxt = tick_r + 4'd1;
            if (tick_r == 4'(SCLK_HALF_CYC - 1)) begin
               tick_nxt = 4'd0;
               sclk_nxt = 1'b1;
               state_nxt = H_HIGH;
            end
         end
         H_HIGH: begin
            tick_nxt = tick_r + 4'd1;
            if (tick_r == 4'(SCLK_HALF_CYC - 1)) begin
               tick_nxt = 4'd0;
               sclk_nxt = 1'b0;
               frame_nxt = {frame_r[30:0], 1'b0};
               bitsLeft_nxt = bitsLeft_r - 6'd1;
               if (bitsLeft_r == 6'd1) begin
                  // Raising select is what launches the operation.
                  csN_nxt = 1'b1;
                  state_nxt = H_GAP;
               end else begin
                  state_nxt = H_LOW;
               end
            end
         end
         H_GAP: begin
            tick_nxt = tick_r + 4'd1;
            if (tick_r == 4'(CS_IDLE_CYC - 1)) begin
               tick_nxt = 4'd0;
               state_nxt = H_IDLE;
            end
         end
         default: state_nxt = H_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= H_IDLE;
         frame_r <= 32'h0000_0000;
         bitsLeft_r <= 6'd0;
         tick_r <= 4'd0;
         sclk_r <= 1'b0;
         csN_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         frame_r <= frame_nxt;
         bitsLeft_r <= bitsLeft_nxt;
         tick_r <= tick_nxt;
         sclk_r <= sclk_nxt;
         csN_r <= csN_nxt;
      end
   end

endmodule

// ### dv/flash_link_checker.sv
// Checker for the serial command link and the decoder result pulses.
`timescale 1ns/1ps
module flash_link_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Serial link
   input wire logic sclk,
   input wire logic csN,
   input wire logic mosi,
   // Issuer request and decoder result
   input wire logic reqValid,
   input wire logic reqReady,
   input wire logic cmdValid,
   input wire logic cmdReject,
   input wire flash_cmd_pkg::cmd_t cmdKind
);
   import flash_cmd_pkg::*;
   logic [7:0] bitCnt_r, bitCnt_nxt, lastCnt_r, lastCnt_nxt;
   logic sclkOld_r;

   // Counts serial clock rises per frame; the last count is kept.
   always_comb begin
      bitCnt_nxt = csN ? 8'h00 : bitCnt_r + {7'h00, sclk & ~sclkOld_r};
      lastCnt_nxt = (csN && bitCnt_r != 8'h00) ? bitCnt_r : lastCnt_r;
   end
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         bitCnt_r <= 8'h00;
         lastCnt_r <= 8'h00;
         sclkOld_r <= 1'b0;
      end else begin
         bitCnt_r <= bitCnt_nxt;
         lastCnt_r <= lastCnt_nxt;
         sclkOld_r <= sclk;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   property p_idle_low;
      csN |-> !sclk;
   endproperty
   a_idle_low: assert property (p_idle_low)
      else $error("serial clock high outside a frame");
   property p_mosi_hold;
      (!csN && sclk) |-> $stable(mosi);
   endproperty
   a_mosi_hold: assert property (p_mosi_hold)
      else $error("data moved while serial clock high");
   property p_frame_gap;
      $rose(csN) |=> csN;
   endproperty
   a_frame_gap: assert property (p_frame_gap)
      else $error("frame select high for under two cycles");
   property p_take;
      (reqValid && reqReady) |=> !reqReady && !csN;
   endproperty
   a_take: assert property (p_take)
      else $error("accepted request did not open a frame");
   property p_frame_len;
      $rose(csN) |-> (bitCnt_r == 8'd8 || bitCnt_r == 8'd32);
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("frame is neither one nor four bytes");
   property p_end_pulse;
      (cmdValid || cmdReject) |-> $past(csN) && !$past(csN, 2);
   endproperty
   a_end_pulse: assert property (p_end_pulse)
      else $error("result pulse not one edge after frame end");
   property p_one_pulse;
      (cmdValid || cmdReject) |=> !cmdValid && !cmdReject;
   endproperty
   a_one_pulse: assert property (p_one_pulse)
      else $error("result pulse longer than one cycle");
   property p_short_cmd;
      (cmdValid && cmdKind inside {CMD_SUSPEND, CMD_RESUME})
         |-> lastCnt_r == 8'd8;
   endproperty
   a_short_cmd: assert property (p_short_cmd)
      else $error("suspend or resume from a long frame");
   property p_long_cmd;
      (cmdValid && !(cmdKind inside {CMD_SUSPEND, CMD_RESUME}))
         |-> lastCnt_r == 8'd32 && cmdKind != CMD_NONE;
   endproperty
   a_long_cmd: assert property (p_long_cmd)
      else $error("addressed or chip command from a short frame");
endmodule

// ### dv/test_flash_program_erase_decoder.sv
// Testbench joining the command issuer to the command decoder.
`timescale 1ns/1ps
module test_flash_program_erase_decoder;
   import flash_cmd_pkg::*;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic mode528 = 1'b1;
   logic reqValid = 1'b0;
   logic [7:0] reqOpcode = 8'h00;
   logic [14:0] reqPage = 15'h0000;
   logic [9:0] reqOffset = 10'h000;
   logic reqReady, cmdValid, cmdReject, bufferTwo, withErase, offsetValid;
   logic v2, r2;
   cmd_t cmdKind, k2;
   logic [7:0] cmdOpcode;
   logic [12:0] pageNum;
   logic [9:0] byteOffset;
   logic [11:0] blockNum;
   logic [31:0] wireBits = 32'h0000_0000;
   int wireCnt = 0;
   int bad_count = 0;
   int n_compared = 0;
   logic [7:0] ops [12] = '{8'h83, 8'h88, 8'h86, 8'h89, 8'h82, 8'h85,
      8'h02, 8'h50, 8'hb0, 8'hd0, 8'hc7, 8'h81};
   flash_link_if link();
   flash_link_if faultLink();

   always #12.5 clk_sys = ~clk_sys;

   flash_cmd_issuer flash_cmd_issuer_i (.clk_sys(clk_sys),
      .arst_n(arst_n), .link(link.ctl), .pageMode528(mode528),
      .reqValid(reqValid), .reqOpcode(reqOpcode), .reqPage(reqPage),
      .reqOffset(reqOffset), .reqReady(reqReady));
   flash_cmd_decoder flash_cmd_decoder_i (.clk_sys(clk_sys),
      .arst_n(arst_n), .link(link.dev), .pageMode528(mode528),
      .cmdValid(cmdValid), .cmdKind(cmdKind), .cmdOpcode(cmdOpcode),
      .bufferTwo(bufferTwo), .withErase(withErase),
      .offsetValid(offsetValid), .pageNum(pageNum),
      .byteOffset(byteOffset), .blockNum(blockNum),
      .cmdReject(cmdReject));
   // The second decoder only ever sees frames that break the rules.
   flash_cmd_decoder flash_cmd_decoder_i2 (.clk_sys(clk_sys),
      .arst_n(arst_n), .link(faultLink.dev), .pageMode528(mode528),
      .cmdValid(v2), .cmdKind(k2), .cmdOpcode(), .bufferTwo(),
      .withErase(), .offsetValid(), .pageNum(), .byteOffset(),
      .blockNum(), .cmdReject(r2));
   flash_link_checker flash_link_checker_i (.clk_sys(clk_sys),
      .arst_n(arst_n), .sclk(link.sclk), .csN(link.csN),
      .mosi(link.mosi), .reqValid(reqValid), .reqReady(reqReady),
      .cmdValid(cmdValid), .cmdReject(cmdReject), .cmdKind(cmdKind));

   // Wire monitor: collects bits on each serial clock rise.
   // A falling select always finds the serial clock low, so one process
   // can both restart the count and collect bits.
   always @(negedge link.csN or posedge link.sclk) begin
      if (!link.sclk) begin
         wireCnt = 0;
      end else if (!link.csN) begin
         wireBits = {wireBits[30:0], link.mosi};
         wireCnt++;
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp,
      input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic tally_and_finish();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Waits for a result pulse; the count bounds a lost frame.
   task automatic waitPulse(input bit alt);
      int n;
      n = 0;
      while ((alt ? (v2 | r2) : (cmdValid | cmdReject)) !== 1'b1 &&
         n < 400) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 400) begin
         bad_count++;
         $display("[ERR] result pulse expected 1 seen 0");
      end
   endtask

   task automatic run(input logic [7:0] op, input logic [14:0] pg,
      input logic [9:0] ofs);
      logic bp, yp, ad, lng, b2, er;
      cmd_t k;
      logic [14:0] p2;
      logic [31:0] w, eOfs, eBlk;
      bp = op inside {8'h83, 8'h86, 8'h88, 8'h89};
      yp = op inside {8'h82, 8'h85, 8'h02};
      b2 = op inside {8'h86, 8'h89, 8'h85};
      er = op inside {8'h83, 8'h86, 8'h82, 8'h85};
      ad = bp || yp || op == 8'h50;
      lng = ad || op == 8'hc7;
      k = bp ? CMD_BUF_PROG : yp ? CMD_BYTE_PROG : CMD_NONE;
      case (op)
         8'h50: k = CMD_BLOCK_ERASE;
         8'hc7: k = CMD_CHIP_ERASE;
         8'hb0: k = CMD_SUSPEND;
         8'hd0: k = CMD_RESUME;
         default: ;
      endcase
      p2 = op == 8'h50 ? {pg[14:3], 3'b000} : pg;
      w = mode528 ? {op, p2[13:0], ofs} : {op, p2, ofs[8:0]};
      w = op == 8'hc7 ? 32'hc794_809a : ad ? w : {24'h00_0000, op};
      eOfs = !yp ? 32'h0 : mode528 ? {22'h0, ofs} : {23'h0, ofs[8:0]};
      eBlk = mode528 ? {21'h0, pg[13:3]} : {20'h0, pg[14:3]};
      while (reqReady !== 1'b1) @(negedge clk_sys);
      reqOpcode = op;
      reqPage = pg;
      reqOffset = ofs;
      reqValid = 1'b1;
      @(negedge clk_sys);
      reqValid = 1'b0;
      waitPulse(1'b0);
      chk("reject", k == CMD_NONE, cmdReject);
      chk("valid", k != CMD_NONE, cmdValid);
      chk("wire", w, lng ? wireBits : {24'h0, wireBits[7:0]});
      chk("bit count", lng ? 32 : 8, wireCnt);
      if (k != CMD_NONE) begin
         chk("kind", k, cmdKind);
         chk("opcode", op, cmdOpcode);
         chk("buffer two", b2, bufferTwo);
         chk("erase", er, withErase);
         chk("offset valid", yp, offsetValid);
         chk("page", (bp || yp) ? pg[12:0] : 13'h0, pageNum);
         chk("offset", eOfs, byteOffset);
         chk("block", op == 8'h50 ? eBlk : 32'h0, blockNum);
      end
   endtask

   // Bit-bangs a bad frame on the second link, MSB first.
   task automatic fault(input logic [31:0] bits, input int n,
      input cmd_t k);
      faultLink.csN = 1'b0;
      for (int i = 0; i < n; i++) begin
         faultLink.mosi = bits[31-i];
         repeat (2) @(negedge clk_sys);
         faultLink.sclk = 1'b1;
         repeat (2) @(negedge clk_sys);
         faultLink.sclk = 1'b0;
      end
      repeat (2) @(negedge clk_sys);
      faultLink.csN = 1'b1;
      faultLink.mosi = ~faultLink.mosi;
      waitPulse(1'b1);
      chk("fault valid", k != CMD_NONE, v2);
      chk("fault reject", k == CMD_NONE, r2);
      if (k != CMD_NONE) chk("fault kind", k, k2);
      repeat (4) @(negedge clk_sys);
   endtask

   initial begin
      faultLink.sclk = 1'b0;
      faultLink.csN = 1'b1;
      faultLink.mosi = 1'b0;
      repeat (12) @(negedge clk_sys);
      arst_n = 1'b1;
      for (int m = 1; m >= 0; m--) begin
         mode528 = m[0];
         foreach (ops[i]) begin
            run(ops[i], m ? 15'h2b5c : 15'h7fff, m ? 10'h2a5 : 10'h3ff);
         end
      end
      fault(32'hc794_809b, 32, CMD_NONE);
      fault(32'hc794_8000, 24, CMD_NONE);
      fault(32'h82ab_cd00, 24, CMD_NONE);
      fault(32'hb012_3456, 32, CMD_SUSPEND);
      fault(32'hd0a0_0000, 11, CMD_RESUME);
      tally_and_finish();
   end

   // Watchdog sized well past the expected run of about 3100 cycles.
   initial begin
      #(25 * 20000);
      bad_count++;
      tally_and_finish();
   end
endmodule
